// [pkg/igc_pkg.sv]
// Behaviour
// - low nibble sets each aux line direction
// - bits 7..4 hold aux lines 4..1 level
// - input lines read back sampled level
// - output lines drive last written level
// - general purpose only when no function assigned
// - upper byte ignored, direction resets to input
// - even address low byte, odd high byte
// - bit 7 enables linear-g gyro compensation
// - bit 6 remaps accel to package corner
// - bit 1 enables daylight saving adjustment
// - bit 0 selects elapsed counter or calendar
// - gyro plus coefficient matrix times accel
// - decimation is bits 10..0, resets zero
// - output rate is base over decimation plus one
// - delta outputs accumulate over whole interval
// - sync clock replaces internal base rate
// - higher priority function wins a shared line
package igc_pkg;
  localparam logic [6:0]  ADDR_PAGE      = 7'h00;
  localparam logic [6:0]  ADDR_FUNC_LO   = 7'h06;
  localparam logic [6:0]  ADDR_FUNC_HI   = 7'h07;
  localparam logic [6:0]  ADDR_AUX_LO    = 7'h08;
  localparam logic [6:0]  ADDR_AUX_HI    = 7'h09;
  localparam logic [6:0]  ADDR_MISC_LO   = 7'h0a;
  localparam logic [6:0]  ADDR_MISC_HI   = 7'h0b;
  localparam logic [6:0]  ADDR_DEC_LO    = 7'h0c;
  localparam logic [6:0]  ADDR_DEC_HI    = 7'h0d;
  localparam logic [7:0]  CFG_PAGE       = 8'h03;
  localparam logic [7:0]  PAGE_RST       = 8'h00;
  localparam logic [15:0] AUX_RST        = 16'h0000;
  localparam logic [15:0] MISC_RST       = 16'h00c0;
  localparam logic [15:0] DEC_RST        = 16'h0000;
  localparam logic [15:0] FUNC_RST       = 16'h000d;
  localparam int          DEC_W          = 11;
  localparam int          MISC_LG_BIT    = 7;
  localparam int          MISC_POP_BIT   = 6;
  localparam int          MISC_DST_BIT   = 1;
  localparam int          MISC_RTC_BIT   = 0;
  localparam int          FN_ALM_EN      = 11;
  localparam int          FN_SYNC_EN     = 7;
  localparam int          FN_DR_EN       = 3;
  localparam int          CMD_WR_BIT     = 15;
  localparam int          SAMPLE_SPS     = 2460;
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          SAMPLE_CYC     = CLK_HZ / SAMPLE_SPS;
  localparam int          SENS_W         = 16;
  localparam int          ACC_W          = 32;

  typedef struct packed {
    logic              valid;
    logic [ACC_W-1:0]  gx;
    logic [ACC_W-1:0]  gy;
    logic [ACC_W-1:0]  gz;
    logic [ACC_W-1:0]  ax;
    logic [ACC_W-1:0]  ay;
    logic [ACC_W-1:0]  az;
  } igc_out_t;

  typedef struct packed {
    logic              valid;
    logic [SENS_W-1:0] gx;
    logic [SENS_W-1:0] gy;
    logic [SENS_W-1:0] gz;
    logic [SENS_W-1:0] ax;
    logic [SENS_W-1:0] ay;
    logic [SENS_W-1:0] az;
  } igc_smp_t;
endpackage : igc_pkg

// [src/igc_coeff_mem.sv]
module igc_coeff_mem #(
  parameter int DEPTH = 9,
  parameter int W     = 16
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [W-1:0]             wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [W-1:0]             rdata_o
);
  logic [W-1:0] mem [DEPTH];
  // no reset: coefficients arrive from calibration load
  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : igc_coeff_mem

// [src/igc_config_bank.sv]
module igc_config_bank (
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 cmd_valid_i,
  input  wire logic [15:0]          cmd_word_i,
  output logic      [7:0]           rd_data_o,
  input  wire logic [3:0]           aux_line_in_i,
  output logic      [3:0]           aux_line_out_o,
  output logic      [3:0]           aux_line_oe_o,
  input  wire logic                 coeff_we_i,
  input  wire logic [3:0]           coeff_addr_i,
  input  wire logic [15:0]          coeff_data_i,
  input  wire igc_pkg::igc_smp_t    smp_i,
  input  wire logic                 data_ready_i,
  input  wire logic                 alarm_i,
  output igc_pkg::igc_out_t         out_o,
  output logic                      accel_corner_o,
  output logic                      dst_en_o,
  output logic                      rtc_elapsed_o
);
  logic [7:0]  page_ff;
  logic [15:0] func_ff, aux_ff, misc_ff, dec_ff;
  logic [3:0]  sync1_ff, sync2_ff, sync3_ff;
  logic [7:0]  rd_ff;

  wire        is_wr   = cmd_valid_i & cmd_word_i[igc_pkg::CMD_WR_BIT];
  wire [6:0]  cmd_adr = cmd_word_i[14:8];
  wire [7:0]  cmd_dat = cmd_word_i[7:0];
  wire        on_pg3  = page_ff == igc_pkg::CFG_PAGE;
  wire        wr_pg   = is_wr & (cmd_adr == igc_pkg::ADDR_PAGE);
  wire        wr_p3   = is_wr & on_pg3;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  // function assignment resolution: lower priority enables are cleared
  logic [15:0] func_wr, func_res;
  always_comb
  begin
    func_wr  = func_ff;
    if (wr_p3 & hit(cmd_adr, igc_pkg::ADDR_FUNC_LO))
    begin
      func_wr[7:0] = cmd_dat;
    end
    if (wr_p3 & hit(cmd_adr, igc_pkg::ADDR_FUNC_HI))
    begin
      func_wr[15:8] = cmd_dat;
    end
    func_res = func_wr;
    if (func_res[igc_pkg::FN_DR_EN] & func_res[igc_pkg::FN_SYNC_EN]
        & (func_res[1:0] == func_res[5:4]))
    begin
      func_res[igc_pkg::FN_SYNC_EN] = 1'b0;
    end
    if (func_res[igc_pkg::FN_ALM_EN] & ((func_res[igc_pkg::FN_DR_EN]
        & (func_res[1:0] == func_res[9:8])) | (func_res[igc_pkg::FN_SYNC_EN]
        & (func_res[5:4] == func_res[9:8]))))
    begin
      func_res[igc_pkg::FN_ALM_EN] = 1'b0;
    end
  end

  // per-line dedicated function map
  logic [3:0] fn_used, fn_out, fn_val;
  always_comb
  begin
    fn_used = '0;
    fn_out  = '0;
    fn_val  = '0;
    for (int i = 0; i < 4; i++)
    begin
      if (func_ff[igc_pkg::FN_ALM_EN] && func_ff[9:8] == 2'(i))
      begin
        fn_used[i] = 1'b1;
        fn_out[i]  = 1'b1;
        fn_val[i]  = ~(alarm_i ^ func_ff[10]);
      end
      if (func_ff[igc_pkg::FN_SYNC_EN] && func_ff[5:4] == 2'(i))
      begin
        fn_used[i] = 1'b1;
        fn_out[i]  = 1'b0;
      end
      if (func_ff[igc_pkg::FN_DR_EN] && func_ff[1:0] == 2'(i))
      begin
        fn_used[i] = 1'b1;
        fn_out[i]  = 1'b1;
        fn_val[i]  = ~(data_ready_i ^ func_ff[2]);
      end
    end
  end

  wire [3:0] gp_dir = aux_ff[3:0];
  wire [3:0] gp_oe  = gp_dir & ~fn_used;
  wire [3:0] pin_oe = gp_oe | (fn_used & fn_out);
  wire [3:0] pin_v  = (gp_oe & aux_ff[7:4]) | (fn_used & fn_val);
  // level bits: inputs show the synchronised pin level
  wire [3:0] lvl_rd = (aux_ff[7:4] & gp_dir) | (sync2_ff & ~gp_dir);

  logic [7:0] rd_mux;
  always_comb
  begin
    case (cmd_adr)
      igc_pkg::ADDR_PAGE:    rd_mux = page_ff;
      igc_pkg::ADDR_FUNC_LO: rd_mux = on_pg3 ? func_ff[7:0] : 8'h00;
      igc_pkg::ADDR_FUNC_HI: rd_mux = on_pg3 ? func_ff[15:8] : 8'h00;
      igc_pkg::ADDR_AUX_LO:  rd_mux = on_pg3 ? {lvl_rd, gp_dir} : 8'h00;
      igc_pkg::ADDR_AUX_HI:  rd_mux = 8'h00;
      igc_pkg::ADDR_MISC_LO: rd_mux = on_pg3 ? misc_ff[7:0] : 8'h00;
      igc_pkg::ADDR_MISC_HI: rd_mux = 8'h00;
      igc_pkg::ADDR_DEC_LO:  rd_mux = on_pg3 ? dec_ff[7:0] : 8'h00;
      igc_pkg::ADDR_DEC_HI:  rd_mux = on_pg3 ? {5'h00, dec_ff[10:8]} : 8'h00;
      default:               rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      page_ff  <= igc_pkg::PAGE_RST;
      func_ff  <= igc_pkg::FUNC_RST;
      aux_ff   <= igc_pkg::AUX_RST;
      misc_ff  <= igc_pkg::MISC_RST;
      dec_ff   <= igc_pkg::DEC_RST;
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      rd_ff    <= '0;
    end
    else
    begin
      sync1_ff <= aux_line_in_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (cmd_valid_i & ~cmd_word_i[igc_pkg::CMD_WR_BIT])
      begin
        rd_ff <= rd_mux;
      end
      if (wr_pg)
      begin
        page_ff <= cmd_dat;
      end
      func_ff <= func_res;
      // low byte only; the high byte is ignored
      if (wr_p3 & hit(cmd_adr, igc_pkg::ADDR_AUX_LO))
      begin
        aux_ff[7:0] <= cmd_dat;
      end
      if (wr_p3 & hit(cmd_adr, igc_pkg::ADDR_MISC_LO))
      begin
        misc_ff[7:0] <= cmd_dat & 8'hc3;
      end
      if (wr_p3 & hit(cmd_adr, igc_pkg::ADDR_DEC_LO))
      begin
        dec_ff[7:0] <= cmd_dat;
      end
      if (wr_p3 & hit(cmd_adr, igc_pkg::ADDR_DEC_HI))
      begin
        dec_ff[10:8] <= cmd_dat[2:0];
      end
    end
  end

  assign rd_data_o      = rd_ff;
  assign accel_corner_o = misc_ff[igc_pkg::MISC_POP_BIT];
  assign dst_en_o       = misc_ff[igc_pkg::MISC_DST_BIT];
  assign rtc_elapsed_o  = misc_ff[igc_pkg::MISC_RTC_BIT];

  logic [3:0] oe_ff, pv_ff;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      oe_ff <= '0;
      pv_ff <= '0;
    end
    else
    begin
      oe_ff <= pin_oe;
      pv_ff <= pin_v;
    end
  end
  assign aux_line_oe_o  = oe_ff;
  assign aux_line_out_o = pv_ff;

  // sample tick: internal divider or selected sync-clock edge
  logic [$clog2(igc_pkg::SAMPLE_CYC)-1:0] div_ff;
  wire [3:0] sync_edge = func_ff[6] ? (sync2_ff & ~sync3_ff) : (~sync2_ff & sync3_ff);
  wire       ext_mode  = func_ff[igc_pkg::FN_SYNC_EN];
  wire       div_end   = div_ff == ($bits(div_ff))'(igc_pkg::SAMPLE_CYC - 1);
  wire       smp_tick  = ext_mode ? sync_edge[func_ff[5:4]] : div_end;

  // linear-g matrix: coefficient index 3*row+col, one term per cycle
  logic [3:0]                          mac_ff;
  logic                                run_ff;
  logic signed [igc_pkg::ACC_W-1:0]    corr_ff [3];
  logic [igc_pkg::SENS_W-1:0]          cf;
  // index 9 marks the last term as summed; keep the read address in range
  wire [3:0] raddr = (mac_ff == 4'd9) ? 4'd8 : mac_ff;
  igc_coeff_mem #(
    .DEPTH (9),
    .W     (igc_pkg::SENS_W)
  ) u_coeff (
    .ref_clk_i (ref_clk_i),
    .we_i      (coeff_we_i),
    .waddr_i   (coeff_addr_i),
    .wdata_i   (coeff_data_i),
    .raddr_i   (raddr),
    .rdata_o   (cf)
  );
  logic [3:0] mac_d;
  wire [1:0] row_d = 2'(mac_d / 4'd3);
  wire [1:0] col_d = 2'(mac_d % 4'd3);
  wire signed [igc_pkg::SENS_W-1:0] a_sel = (col_d == 2'd0) ? smp_i.ax :
                                            (col_d == 2'd1) ? smp_i.ay : smp_i.az;
  wire signed [igc_pkg::ACC_W-1:0] prod = $signed(cf) * a_sel;

  logic [10:0] cnt_ff;
  logic signed [igc_pkg::ACC_W-1:0] sum_ff [6];
  wire  last_ok = run_ff & (mac_d == 4'd9);
  wire  dec_end = cnt_ff == dec_ff[10:0];
  wire  smp_go  = smp_tick & smp_i.valid & ~run_ff;
  wire  lg_en   = misc_ff[igc_pkg::MISC_LG_BIT];

  // signed zero keeps the sums signed, so negative samples extend correctly
  localparam logic signed [igc_pkg::ACC_W-1:0] ZERO_S = '0;
  logic signed [igc_pkg::SENS_W-1:0] smp_s   [6];
  logic signed [igc_pkg::ACC_W-1:0]  nxt_sum [6];
  always_comb
  begin
    smp_s[0] = smp_i.gx;
    smp_s[1] = smp_i.gy;
    smp_s[2] = smp_i.gz;
    smp_s[3] = smp_i.ax;
    smp_s[4] = smp_i.ay;
    smp_s[5] = smp_i.az;
  end
  // closing sample belongs to the interval it ends
  for (genvar g = 0; g < 6; g++)
  begin : g_sum
    assign nxt_sum[g] = sum_ff[g] + smp_s[g]
                        + ((g < 3 && lg_en) ? corr_ff[g % 3] : ZERO_S);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_ff <= '0;
      mac_ff <= '0;
      mac_d  <= '0;
      run_ff <= 1'b0;
      cnt_ff <= '0;
      out_o  <= '0;
      for (int k = 0; k < 3; k++) corr_ff[k] <= '0;
      for (int k = 0; k < 6; k++) sum_ff[k] <= '0;
    end
    else
    begin
      div_ff <= div_end ? '0 : div_ff + 1'b1;
      mac_d  <= mac_ff;
      out_o.valid <= 1'b0;
      if (smp_go)
      begin
        run_ff <= 1'b1;
        mac_ff <= '0;
        // read word of this cycle is stale; never sum it
        mac_d  <= 4'hf;
        for (int k = 0; k < 3; k++) corr_ff[k] <= '0;
      end
      else if (run_ff)
      begin
        mac_ff <= (mac_ff == 4'd9) ? mac_ff : mac_ff + 1'b1;
        if (mac_d <= 4'd8)
        begin
          corr_ff[row_d] <= corr_ff[row_d] + prod;
        end
        if (last_ok)
        begin
          run_ff <= 1'b0;
          // accumulate across the whole decimated interval
          for (int k = 0; k < 6; k++)
          begin
            sum_ff[k] <= dec_end ? ZERO_S : nxt_sum[k];
          end
          cnt_ff <= dec_end ? '0 : cnt_ff + 1'b1;
          if (dec_end)
          begin
            out_o.valid <= 1'b1;
            out_o.gx <= nxt_sum[0];
            out_o.gy <= nxt_sum[1];
            out_o.gz <= nxt_sum[2];
            out_o.ax <= nxt_sum[3];
            out_o.ay <= nxt_sum[4];
            out_o.az <= nxt_sum[5];
          end
        end
      end
    end
  end
endmodule : igc_config_bank

// [bench/igc_config_bank_props.sv]
module igc_config_bank_props (
  input wire logic              ref_clk_i,
  input wire logic              reset_n_i,
  input wire logic              cmd_valid_i,
  input wire logic [15:0]       cmd_word_i,
  input wire logic [7:0]        rd_data_o,
  input wire logic [3:0]        aux_line_oe_o,
  input wire igc_pkg::igc_out_t out_o,
  input wire logic              accel_corner_o,
  input wire logic              dst_en_o,
  input wire logic              rtc_elapsed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] page_ff;
  logic [7:0] nxt_page;
  wire        wr_cmd  = cmd_valid_i && cmd_word_i[15];
  wire        rd_cmd  = cmd_valid_i && !cmd_word_i[15];
  wire  [6:0] adr     = cmd_word_i[14:8];
  wire        on_pg   = (page_ff == igc_pkg::CFG_PAGE);
  wire        misc_wr = wr_cmd && on_pg && (adr == igc_pkg::ADDR_MISC_LO);
  // shadow of the page selector, so refusals can be judged
  assign nxt_page = (wr_cmd && adr == igc_pkg::ADDR_PAGE) ? cmd_word_i[7:0] : page_ff;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
    if (!reset_n_i) page_ff <= igc_pkg::PAGE_RST;
    else page_ff <= nxt_page;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_OE_RST: assert property ($rose(reset_n_i) |-> aux_line_oe_o == 4'h0)
    else $error("aux line driven right after reset");
  AST_MISC_RST: assert property ($rose(reset_n_i)
    |-> accel_corner_o && !dst_en_o && !rtc_elapsed_o)
    else $error("misc outputs wrong after reset");
  AST_CORNER: assert property (misc_wr |=> accel_corner_o == $past(cmd_word_i[6]))
    else $error("corner remap does not follow write");
  AST_DST: assert property (misc_wr |=> dst_en_o == $past(cmd_word_i[1]))
    else $error("dst enable does not follow write");
  AST_RTC: assert property (misc_wr ##1 !misc_wr
    |=> $stable(rtc_elapsed_o) && rtc_elapsed_o == $past(cmd_word_i[0], 2))
    else $error("rtc mode does not follow write");
  AST_AUXHI: assert property (rd_cmd && adr == igc_pkg::ADDR_AUX_HI
    |=> rd_data_o == 8'h00)
    else $error("aux upper byte not zero");
  AST_DECHI: assert property (rd_cmd && on_pg && adr == igc_pkg::ADDR_DEC_HI
    |=> rd_data_o[7:3] == 5'h00)
    else $error("decimation upper bits not zero");
  AST_OFFPG: assert property (rd_cmd && !on_pg && adr >= igc_pkg::ADDR_AUX_LO
    && adr <= igc_pkg::ADDR_DEC_HI |=> rd_data_o == 8'h00)
    else $error("register readable off page");
  AST_RD_HOLD: assert property (!rd_cmd |=> $stable(rd_data_o))
    else $error("read byte changed without read");

  COV_MISC: cover property (misc_wr ##1 dst_en_o);
  COV_DECHI: cover property (rd_cmd && on_pg && adr == igc_pkg::ADDR_DEC_HI);
  COV_OUT: cover property (out_o.valid);
endmodule : igc_config_bank_props

bind igc_config_bank igc_config_bank_props u_props (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
  .cmd_word_i(cmd_word_i), .rd_data_o(rd_data_o), .aux_line_oe_o(aux_line_oe_o),
  .out_o(out_o), .accel_corner_o(accel_corner_o), .dst_en_o(dst_en_o),
  .rtc_elapsed_o(rtc_elapsed_o));

// [bench/igc_host_model.sv]
module igc_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic [7:0]  rd_data_i,
  output logic             cmd_valid_o,
  output logic      [15:0] cmd_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_word_o  = 16'h0000;
  end
  task automatic issue(input logic [15:0] w);
    @(negedge ref_clk_i);
    cmd_valid_o = 1'b1;
    cmd_word_o  = w;
    @(negedge ref_clk_i);
    cmd_valid_o = 1'b0;
    // idle bus shows no stale command
    cmd_word_o  = ~w;
  endtask : issue
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    issue({1'b1, a, d});
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    issue({1'b0, a, 8'h00});
    @(posedge ref_clk_i);
    #1 d = rd_data_i;
  endtask : rd
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 7'h01, v[15:8]);
  endtask : wr16
  task automatic page3();
    wr(igc_pkg::ADDR_PAGE, igc_pkg::CFG_PAGE);
  endtask : page3
endmodule : igc_host_model

// [bench/test_imu_gpio_config_decimation.sv]
module test_imu_gpio_config_decimation;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk_i, reset_n_i, cmd_valid, data_ready_i, coeff_we;
  logic       [15:0] cmd_word;
  logic       [7:0]  rd_data, b;
  logic       [3:0]  aux_out, aux_oe, ext, coeff_addr;
  logic              corner, dst, rtc;
  logic       [15:0] coeff_data;
  igc_pkg::igc_smp_t smp;
  igc_pkg::igc_out_t outp;
  logic       [31:0] gx_seen;
  int                error_cnt, samples_checked, cyc, n_out;
  // wire level: device drives where enabled, else the outside world
  wire        [3:0]  aux_in = (aux_oe & aux_out) | (~aux_oe & ext);

  igc_config_bank uut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid),
    .cmd_word_i(cmd_word), .rd_data_o(rd_data), .aux_line_in_i(aux_in),
    .aux_line_out_o(aux_out), .aux_line_oe_o(aux_oe), .coeff_we_i(coeff_we),
    .coeff_addr_i(coeff_addr), .coeff_data_i(coeff_data), .smp_i(smp),
    .data_ready_i(data_ready_i), .alarm_i(1'b0), .out_o(outp),
    .accel_corner_o(corner), .dst_en_o(dst), .rtc_elapsed_o(rtc));
  igc_host_model u_host (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data),
    .cmd_valid_o(cmd_valid), .cmd_word_o(cmd_word));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [6:0] a, input logic [7:0] e);
    u_host.rd(a, b);
    chk(nm, 32'(b), 32'(e));
  endtask : rchk
  task automatic pulse(input int n);
    repeat (n)
    begin
      ext[3] = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      ext[3] = 1'b0;
      repeat (8) @(negedge ref_clk_i);
    end
  endtask : pulse
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (outp.valid === 1'b1)
    begin
      n_out++;
      gx_seen = outp.gx;
    end
    if (cyc == 5000)
    begin
      error_cnt++;
      summarize();
    end
  end

  initial
  begin
    reset_n_i = 1'b0;
    ext = 4'h0;
    data_ready_i = 1'b1;
    smp = '0;
    coeff_we = 1'b0;
    coeff_addr = 4'h0;
    coeff_data = 16'h0000;
    repeat (2) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    chk("oe at reset", 32'(aux_oe), 32'h0000_0000);
    rchk("off page", igc_pkg::ADDR_MISC_LO, 8'h00);
    u_host.page3();
    rchk("misc lo", igc_pkg::ADDR_MISC_LO, 8'hc0);
    rchk("misc hi", igc_pkg::ADDR_MISC_HI, 8'h00);
    rchk("dec lo", igc_pkg::ADDR_DEC_LO, 8'h00);
    // line 2 carries data ready after reset, so its level reads high
    rchk("aux rst", igc_pkg::ADDR_AUX_LO, 8'h20);
    u_host.wr16(igc_pkg::ADDR_AUX_LO, 16'h0015);
    repeat (2) @(negedge ref_clk_i);
    chk("oe", 32'(aux_oe), 32'h0000_0007);
    chk("out", 32'(aux_out[2:0]), 32'h0000_0003);
    data_ready_i = 1'b0;
    ext = 4'h8;
    repeat (4) @(negedge ref_clk_i);
    chk("ready line", 32'(aux_out[1]), 32'h0000_0000);
    rchk("aux lo", igc_pkg::ADDR_AUX_LO, 8'h95);
    u_host.wr(igc_pkg::ADDR_AUX_HI, 8'hff);
    rchk("aux hi", igc_pkg::ADDR_AUX_HI, 8'h00);
    u_host.wr(igc_pkg::ADDR_MISC_LO, 8'h03);
    chk("misc pins", 32'({corner, dst, rtc}), 32'h0000_0003);
    rchk("misc lg off", igc_pkg::ADDR_MISC_LO, 8'h03);
    u_host.wr(igc_pkg::ADDR_MISC_LO, 8'h40);
    chk("misc pins2", 32'({corner, dst, rtc}), 32'h0000_0004);
    u_host.wr16(igc_pkg::ADDR_DEC_LO, 16'hffff);
    rchk("dec lo max", igc_pkg::ADDR_DEC_LO, 8'hff);
    rchk("dec hi max", igc_pkg::ADDR_DEC_HI, 8'h07);
    u_host.wr(igc_pkg::ADDR_FUNC_LO, 8'h88);
    rchk("func clash", igc_pkg::ADDR_FUNC_LO, 8'h08);
    u_host.wr16(igc_pkg::ADDR_DEC_LO, 16'h0002);
    ext = 4'h0;
    smp.valid = 1'b1;
    smp.gx = 16'h0010;
    u_host.wr(igc_pkg::ADDR_FUNC_LO, 8'hf0);
    n_out = 0;
    pulse(2);
    chk("early out", 32'(n_out), 32'h0000_0000);
    pulse(1);
    repeat (40) @(negedge ref_clk_i);
    chk("out count", 32'(n_out), 32'h0000_0001);
    chk("gx sum", gx_seen, 32'h0000_0030);
    for (int k = 0; k < 9; k++)
    begin
      coeff_we = 1'b1;
      coeff_addr = 4'(k);
      coeff_data = (k == 0) ? 16'h0002 : 16'h0000;
      @(negedge ref_clk_i);
    end
    coeff_we = 1'b0;
    smp.ax = 16'h0004;
    u_host.wr(igc_pkg::ADDR_MISC_LO, 8'hc0);
    u_host.wr16(igc_pkg::ADDR_DEC_LO, 16'h0000);
    n_out = 0;
    pulse(1);
    repeat (40) @(negedge ref_clk_i);
    chk("lg out count", 32'(n_out), 32'h0000_0001);
    chk("gx lg", gx_seen, 32'h0000_0018);
    u_host.wr(igc_pkg::ADDR_FUNC_HI, 8'h0b);
    rchk("alarm clash", igc_pkg::ADDR_FUNC_HI, 8'h03);
    summarize();
  end
endmodule : test_imu_gpio_config_decimation
